// ### include/tlp_regs.vh
// Constants of the tri-level PWM sequencer: level codes, timing figures and derived cycle counts.
// Assumes a 100 MHz core clock; included by the design files by bare name.
`ifndef TLP_REGS_VH
`define TLP_REGS_VH
`define TLP_CLK_MHZ          100
`define TLP_LVL_LOW          2'h0
`define TLP_LVL_HIGH         2'h1
`define TLP_LVL_MID          2'h2
`define TLP_OSC_MIN_KHZ      500
`define TLP_OSC_MAX_KHZ      3000
`define TLP_SYNC_MIN_KHZ     588
`define TLP_SYNC_LOSS_PCT    15
`define TLP_REFRESH_COUNT    32
`define TLP_REFRESH_EXTRA    4
`define TLP_TRI_TIMER_US     60
`define TLP_TRI_TIMER_CYC    (`TLP_TRI_TIMER_US * `TLP_CLK_MHZ)
`define TLP_MIN_ON_NS        120
`define TLP_MIN_ON_CYC       ((`TLP_MIN_ON_NS * `TLP_CLK_MHZ + 999) / 1000)
`define TLP_OSC_HALF_MAX_CYC ((`TLP_CLK_MHZ * 1000) / (2 * `TLP_OSC_MIN_KHZ))
`define TLP_OSC_HALF_MIN_CYC ((`TLP_CLK_MHZ * 1000 + 2 * `TLP_OSC_MAX_KHZ - 1) / (2 * `TLP_OSC_MAX_KHZ))
`endif

// ### design/tlp_osc_sel.v
// Reference-clock generator: internal oscillator divider with external sync follow and fallback.
// Assumes sync_in is synchronous to clk_in; produces one-cycle tick pulses, never a derived clock.
`timescale 1ns/1ns
`include "tlp_regs.vh"
module tlp_osc_sel #(
    parameter HALF_W = 16
) (
    input  wire              clk_in,
    input  wire              rst_in,
    input  wire [HALF_W-1:0] half_period_in,
    input  wire              sync_in,
    output reg               osc_tick_out,
    output reg               sync_lock_out
);
    reg  [HALF_W-1:0] div_r;
    reg               sync_d_r;
    reg  [HALF_W+1:0] watch_r;
    wire              sync_rise;
    wire [HALF_W+1:0] loss_lim;

    assign sync_rise = sync_in & ~sync_d_r;
    // Five half periods without a sync edge mean that the sync source has stopped.
    assign loss_lim  = {half_period_in, 2'b00} + {2'b00, half_period_in};

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r         <= {HALF_W{1'b0}};
            sync_d_r      <= 1'b0;
            watch_r       <= {(HALF_W+2){1'b0}};
            sync_lock_out <= 1'b0;
            osc_tick_out  <= 1'b0;
        end else begin
            sync_d_r <= sync_in;
            if (sync_rise) begin
                watch_r       <= {(HALF_W+2){1'b0}};
                sync_lock_out <= 1'b1;
            end else if (watch_r >= loss_lim) begin
                sync_lock_out <= 1'b0;
            end else begin
                watch_r <= watch_r + 1'b1;
            end
            // A sync edge earlier than half a period after the last tick is ignored, so no tick comes short.
            // The divider keeps ticking when sync edges stop, so a lost sync costs no pulse.
            if (sync_rise && div_r >= half_period_in) begin
                div_r        <= {HALF_W{1'b0}};
                osc_tick_out <= 1'b1;
            end else if (div_r >= half_period_in + half_period_in - 1'b1) begin
                div_r        <= {HALF_W{1'b0}};
                osc_tick_out <= 1'b1;
            end else begin
                div_r        <= div_r + 1'b1;
                osc_tick_out <= 1'b0;
            end
        end
    end
endmodule // tlp_osc_sel

// ### design/tlp_sequencer.v
// Tri-level PWM sequencer: phase configuration, boot refresh, peak-current pulses and sync output.
// Assumes all inputs synchronous to clk_in; the analog loop drives the comparator inputs.
// Summary of operation
// - Dual-phase after reset unless exactly one output is strapped high at configuration.
// - One strapped phase: run single-phase on the other, either may be active.
// - Frequency-set short to ground is a fault; all switching stops.
// - Internal oscillator programmable from 500 kHz to 3 MHz by frequency-set.
// - Follow external sync when present; fall back to internal oscillator when it stops.
// - Each phase switches at half the oscillator or sync rate.
// - Sync output: oscillator rate when strapped low, switching rate when strapped high.
// - Unstrapped sync output is in phase with the second phase output.
// - Sync output held low while any fault is active.
// - High pulse ends as soon as that phase's comparator trips.
// - Two independent comparator inputs, one per phase.
// - Three-level encoding: high, low, mid; driver obeys it.
// - Power-up boot refresh of 32 mid-to-low transitions per active phase.
// - Refresh pulses at switching rate, each low pulse exactly minimum on-time.
// - Mid entry starts 60 us timer; expiry before high sends four refresh pulses.
// - Second phase shifted 180 degrees from the first in dual-phase.
`timescale 1ns/1ns
`include "tlp_regs.vh"
module tlp_sequencer #(
    parameter HALF_W    = 16,
    parameter TRI_CYC   = `TLP_TRI_TIMER_CYC,
    parameter MIN_ON    = `TLP_MIN_ON_CYC,
    parameter N_REFRESH = `TLP_REFRESH_COUNT,
    parameter N_EXTRA   = `TLP_REFRESH_EXTRA
) (
    input  wire              clk_in,
    input  wire              rst_in,
    input  wire              config_in,
    input  wire              strap_a_high_in,
    input  wire              strap_b_high_in,
    input  wire              sync_strap_low_in,
    input  wire              sync_strap_high_in,
    input  wire [HALF_W-1:0] freq_set_in,
    input  wire              freq_set_short_in,
    input  wire              fault_in,
    input  wire              run_in,
    input  wire              sync_in,
    input  wire              peak_trip_a_in,
    input  wire              peak_trip_b_in,
    output reg  [1:0]        phase_a_out,
    output reg  [1:0]        phase_b_out,
    output reg               sync_out,
    output reg               single_phase_out,
    output reg               refresh_busy_out,
    output wire              sync_lock_out
);
    localparam ST_IDLE    = 2'h0;
    localparam ST_REFRESH = 2'h1;
    localparam ST_RUN     = 2'h2;
    localparam ST_MID     = 2'h3;
    localparam [HALF_W-1:0] HALF_LO = `TLP_OSC_HALF_MIN_CYC;
    localparam [HALF_W-1:0] HALF_HI = `TLP_OSC_HALF_MAX_CYC;

    reg  [1:0]        state_r;
    reg  [1:0]        state_nxt;
    reg               en_a_r;
    reg               en_b_r;
    reg               tog_r;
    reg  [5:0]        rcnt_r;
    reg  [31:0]       tri_r;
    reg  [15:0]       pw_r;
    reg               trip_a_r;
    reg               trip_b_r;
    reg               first_done_r;
    wire              osc_tick;
    wire              fault;
    wire              sw_a_tick;
    wire              sw_b_tick;
    wire [HALF_W-1:0] half_per;

    function [HALF_W-1:0] clamp_half;
        input [HALF_W-1:0] v;
        begin
            if (v < HALF_LO)
                clamp_half = HALF_LO;
            else if (v > HALF_HI)
                clamp_half = HALF_HI;
            else
                clamp_half = v;
        end
    endfunction

    assign half_per  = clamp_half(freq_set_in);
    assign fault     = fault_in | freq_set_short_in;
    // Phase A fires on even oscillator ticks, phase B on odd ones: each at half rate, 180 apart.
    assign sw_a_tick = osc_tick & ~tog_r;
    assign sw_b_tick = osc_tick &  tog_r;

    tlp_osc_sel #(
        .HALF_W(HALF_W)
    ) u_osc (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .half_period_in (half_per),
        .sync_in        (sync_in),
        .osc_tick_out   (osc_tick),
        .sync_lock_out  (sync_lock_out)
    );

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            en_a_r           <= 1'b1;
            en_b_r           <= 1'b1;
            single_phase_out <= 1'b0;
        end else if (config_in) begin
            // A strap on both outputs is meaningless; dual-phase is kept then.
            if (strap_a_high_in && !strap_b_high_in) begin
                en_a_r           <= 1'b0;
                en_b_r           <= 1'b1;
                single_phase_out <= 1'b1;
            end else if (strap_b_high_in && !strap_a_high_in) begin
                en_a_r           <= 1'b1;
                en_b_r           <= 1'b0;
                single_phase_out <= 1'b1;
            end else begin
                en_a_r           <= 1'b1;
                en_b_r           <= 1'b1;
                single_phase_out <= 1'b0;
            end
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (run_in && !config_in)
                    state_nxt = ST_REFRESH;
            end
            ST_REFRESH: begin
                if (rcnt_r == 6'h00 && pw_r == 16'h0000 && sw_b_tick)
                    state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (!run_in)
                    state_nxt = ST_MID;
            end
            ST_MID: begin
                if (run_in)
                    state_nxt = ST_RUN;
                else if (tri_r >= TRI_CYC - 1)
                    state_nxt = ST_REFRESH;
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (fault)
            state_nxt = ST_IDLE;
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r          <= ST_IDLE;
            tog_r            <= 1'b0;
            rcnt_r           <= 6'h00;
            tri_r            <= 32'h0000_0000;
            pw_r             <= 16'h0000;
            trip_a_r         <= 1'b0;
            trip_b_r         <= 1'b0;
            first_done_r     <= 1'b0;
            refresh_busy_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (osc_tick)
                tog_r <= ~tog_r;
            if (state_r != ST_REFRESH && state_nxt == ST_REFRESH) begin
                rcnt_r       <= first_done_r ? N_EXTRA[5:0] : N_REFRESH[5:0];
                first_done_r <= 1'b1;
            end else if (state_r == ST_REFRESH && sw_a_tick && rcnt_r != 6'h00) begin
                rcnt_r <= rcnt_r - 1'b1;
            end
            if (state_r == ST_REFRESH && sw_a_tick && rcnt_r != 6'h00)
                pw_r <= MIN_ON[15:0];
            else if (pw_r != 16'h0000)
                pw_r <= pw_r - 1'b1;
            if (state_r == ST_MID)
                tri_r <= tri_r + 1'b1;
            else
                tri_r <= 32'h0000_0000;
            // A trip holds the phase off until its next switching edge.
            if (peak_trip_a_in)
                trip_a_r <= 1'b1;
            else if (sw_a_tick)
                trip_a_r <= 1'b0;
            if (peak_trip_b_in)
                trip_b_r <= 1'b1;
            else if (sw_b_tick)
                trip_b_r <= 1'b0;
            refresh_busy_out <= (state_nxt == ST_REFRESH);
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_a_out <= `TLP_LVL_MID;
            phase_b_out <= `TLP_LVL_MID;
            sync_out    <= 1'b0;
        end else begin
            if (fault || state_r == ST_IDLE || state_r == ST_MID) begin
                phase_a_out <= `TLP_LVL_MID;
                phase_b_out <= `TLP_LVL_MID;
            end else if (state_r == ST_REFRESH) begin
                phase_a_out <= (en_a_r && pw_r != 16'h0000) ? `TLP_LVL_LOW : `TLP_LVL_MID;
                phase_b_out <= (en_b_r && pw_r != 16'h0000) ? `TLP_LVL_LOW : `TLP_LVL_MID;
            end else begin
                if (!en_a_r)
                    phase_a_out <= `TLP_LVL_MID;
                // The latched trip yields to the next switching tick, so only a trip present at a switching tick costs a whole period.
                else if (peak_trip_a_in || (trip_a_r && !sw_a_tick))
                    phase_a_out <= `TLP_LVL_LOW;
                else if (sw_a_tick)
                    phase_a_out <= `TLP_LVL_HIGH;
                if (!en_b_r)
                    phase_b_out <= `TLP_LVL_MID;
                else if (peak_trip_b_in || (trip_b_r && !sw_b_tick))
                    phase_b_out <= `TLP_LVL_LOW;
                else if (sw_b_tick)
                    phase_b_out <= `TLP_LVL_HIGH;
            end
            if (fault)
                sync_out <= 1'b0;
            else if (sync_strap_low_in) begin
                if (osc_tick)
                    sync_out <= 1'b1;
                else if (pw_r == 16'h0000)
                    sync_out <= 1'b0;
            end else if (sync_strap_high_in) begin
                if (sw_a_tick)
                    sync_out <= 1'b1;
                else if (sw_b_tick)
                    sync_out <= 1'b0;
            end else begin
                if (sw_b_tick)
                    sync_out <= 1'b1;
                else if (sw_a_tick)
                    sync_out <= 1'b0;
            end
        end
    end
endmodule // tlp_sequencer

// ### bench/tlp_drv_model.sv
// Half-bridge driver model fed by one tri-level phase output.
// Assumes the phase code is registered on clk_in.
`timescale 1ns/1ns
module tlp_drv_model (
    input  wire       clk_in,
    input  wire [1:0] phase_in,
    output reg        hs_on_out,
    output reg        ls_on_out
);
    // Mid leaves both switches off, so no code can turn both on together.
    always @(posedge clk_in) begin
        hs_on_out <= (phase_in == 2'h1);
        ls_on_out <= (phase_in == 2'h0);
    end
endmodule // tlp_drv_model

// ### bench/tlp_seq_sva.sv
// Checker on the ports of the tri-level sequencer.
// Bound to tlp_sequencer; one clock domain, reset rst_in.
`timescale 1ns/1ns
module tlp_seq_sva #(
    parameter MIN_ON = 12
) (
    input wire       clk_in,
    input wire       rst_in,
    input wire       config_in,
    input wire       freq_set_short_in,
    input wire       fault_in,
    input wire       run_in,
    input wire       peak_trip_a_in,
    input wire       peak_trip_b_in,
    input wire [1:0] phase_a_out,
    input wire [1:0] phase_b_out,
    input wire       sync_out,
    input wire       refresh_busy_out
);
    reg [7:0] low_r;
    // Counts how long phase A has sat low, to judge refresh pulse width.
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            low_r <= 8'h00;
        end else begin
            low_r <= (phase_a_out == 2'h0) ? low_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_fault; fault_in |=> phase_a_out == 2'h2 && phase_b_out == 2'h2 && !sync_out; endproperty
    a_fault: assert property (p_fault) else $error("fault not honoured");
    property p_short; freq_set_short_in |=> phase_a_out == 2'h2 && phase_b_out == 2'h2; endproperty
    a_short: assert property (p_short) else $error("short not honoured");
    property p_code; phase_a_out != 2'h3 && phase_b_out != 2'h3; endproperty
    a_code: assert property (p_code) else $error("illegal level");
    property p_trip_a; (phase_a_out == 2'h1 && peak_trip_a_in) |-> ##[1:2] phase_a_out != 2'h1; endproperty
    a_trip_a: assert property (p_trip_a) else $error("trip a ignored");
    property p_trip_b; (phase_b_out == 2'h1 && peak_trip_b_in) |-> ##[1:2] phase_b_out != 2'h1; endproperty
    a_trip_b: assert property (p_trip_b) else $error("trip b ignored");
    property p_refresh; refresh_busy_out |-> phase_a_out != 2'h1 && phase_b_out != 2'h1; endproperty
    a_refresh: assert property (p_refresh) else $error("high in refresh");
    property p_min_on;
        ($past(refresh_busy_out) && $past(phase_a_out) == 2'h0 && phase_a_out == 2'h2 && !$past(fault_in))
            |-> low_r == MIN_ON;
    endproperty
    a_min_on: assert property (p_min_on) else $error("refresh width");
    property p_mid; (!run_in && !config_in)[*2] |=> phase_a_out != 2'h1 && phase_b_out != 2'h1; endproperty
    a_mid: assert property (p_mid) else $error("high while mid");
endmodule // tlp_seq_sva
bind tlp_sequencer tlp_seq_sva #(.MIN_ON(MIN_ON)) u_sva (.clk_in(clk_in), .rst_in(rst_in), .config_in(config_in),
    .freq_set_short_in(freq_set_short_in), .fault_in(fault_in), .run_in(run_in), .peak_trip_a_in(peak_trip_a_in),
    .peak_trip_b_in(peak_trip_b_in), .phase_a_out(phase_a_out), .phase_b_out(phase_b_out), .sync_out(sync_out),
    .refresh_busy_out(refresh_busy_out));

// ### bench/tb_top.sv
// Self-checking bench for the tri-level sequencer.
// Assumes the driver model and the bound checker; a local generator stands in for the external sync source.
`timescale 1ns/1ns
`include "tlp_regs.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; $display("FAIL %s exp %0h got %0h", n, e, a); end end
module tb_top;
    reg        clk_in = 1'b0, rst_in = 1'b1, config_in = 1'b1, strap_b_high_in = 1'b0;
    reg        fault_in = 1'b0, freq_set_short_in = 1'b0, run_in = 1'b0;
    reg        peak_trip_a_in = 1'b0, peak_trip_b_in = 1'b0;
    reg        sync_in = 1'b0, sync_on = 1'b0, sync_lo = 1'b0, sync_hi = 1'b0;
    reg [15:0] freq_set = 16'h0011;
    wire [1:0] phase_a_out, phase_b_out;
    wire       sync_out, single_phase_out, refresh_busy_out, hs_a, ls_a, lock;
    int        fails = 0, checks_done = 0, na, nb, bw, k, sc = 0;
    always #5 clk_in = ~clk_in;
    // External sync at 2.5 MHz: inside its allowed band and 25% above the 2 MHz internal rate used with it.
    always @(posedge clk_in) begin
        sc <= (sc == 39) ? 0 : sc + 1;
        sync_in <= sync_on && (sc < 20);
    end
    tlp_sequencer #(.TRI_CYC(200)) uut (.clk_in(clk_in), .rst_in(rst_in), .config_in(config_in),
        .strap_a_high_in(1'b0), .strap_b_high_in(strap_b_high_in), .sync_strap_low_in(sync_lo),
        .sync_strap_high_in(sync_hi), .freq_set_in(freq_set), .freq_set_short_in(freq_set_short_in),
        .fault_in(fault_in), .run_in(run_in), .sync_in(sync_in), .peak_trip_a_in(peak_trip_a_in),
        .peak_trip_b_in(peak_trip_b_in), .phase_a_out(phase_a_out), .phase_b_out(phase_b_out),
        .sync_out(sync_out), .single_phase_out(single_phase_out), .refresh_busy_out(refresh_busy_out),
        .sync_lock_out(lock));
    tlp_drv_model drv_a (.clk_in(clk_in), .phase_in(phase_a_out), .hs_on_out(hs_a), .ls_on_out(ls_a));
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task do_reset(input logic sb);
        rst_in <= 1'b1;
        config_in <= 1'b1;
        strap_b_high_in <= sb;
        run_in <= 1'b0;
        cyc(4);
        rst_in <= 1'b0;
        cyc(4);
        config_in <= 1'b0;
        cyc(2);
        #1;
    endtask
    // Counts low pulses until phase A first goes high; raises run_in at cycle raise.
    task count_lows(input int raise);
        logic [1:0] pa, pb;
        int wa;
        na = 0; nb = 0; bw = 0; wa = 0; pa = 2'h2; pb = 2'h2;
        for (k = 0; k < 20000; k++) begin
            @(posedge clk_in);
            if (k == raise) run_in <= 1'b1;
            #1;
            if (phase_a_out === 2'h1) break;
            if (phase_a_out === 2'h0) wa++;
            else if (pa === 2'h0) begin na++; if (wa != `TLP_MIN_ON_CYC) bw++; wa = 0; end
            if (phase_b_out === 2'h0 && pb !== 2'h0) nb++;
            pa = phase_a_out; pb = phase_b_out;
        end
        if (k == 20000) begin fails++; conclude(); end
    endtask
    task t_trip;
        @(posedge clk_in) peak_trip_a_in <= 1'b1;
        cyc(3); #1;
        `CHK("trip_a", 2'h0, phase_a_out)
        `CHK("hs_a", 1'b0, hs_a)
        `CHK("ls_a", 1'b1, ls_a)
        @(posedge clk_in) peak_trip_a_in <= 1'b0;
        for (k = 0; k < 1000 && phase_b_out !== 2'h1; k++) begin @(posedge clk_in); #1; end
        if (k == 1000) begin fails++; conclude(); end
        // Five edges pass before the wait; phase B should rise two half periods of 17 cycles, 34 in all, after phase A.
        `CHK("shift", 2 * 17 - 5, k)
        `CHK("sync_b", 1'b1, sync_out)
        @(posedge clk_in) peak_trip_b_in <= 1'b1;
        cyc(3); #1;
        `CHK("trip_b", 2'h0, phase_b_out)
        @(posedge clk_in) peak_trip_b_in <= 1'b0;
    endtask
    task t_fault;
        @(posedge clk_in) fault_in <= 1'b1;
        nb = 0;
        for (k = 0; k < 40; k++) begin @(posedge clk_in); #1; if (k > 0 && sync_out !== 1'b0) nb++; end
        `CHK("sync_held", 0, nb)
        `CHK("fault_a", 2'h2, phase_a_out)
        @(posedge clk_in) fault_in <= 1'b0;
        // Let switching resume on both phases so that the short has something to stop.
        count_lows(0);
        cyc(40); #1;
        `CHK("run_b", 2'h1, phase_b_out)
        @(posedge clk_in) freq_set_short_in <= 1'b1;
        cyc(2); #1;
        `CHK("short_a", 2'h2, phase_a_out)
        `CHK("short_b", 2'h2, phase_b_out)
        @(posedge clk_in) freq_set_short_in <= 1'b0;
    endtask
    // Lets the sync output settle, then compares the cycles between two of its rising edges with exp.
    task sync_period(input string n, input int exp);
        logic s;
        int c, e;
        c = 0;
        e = 0;
        cyc(100); #1;
        s = sync_out;
        for (k = 0; k < 1000 && e < 2; k++) begin
            @(posedge clk_in); #1;
            if (e == 1) c++;
            if (sync_out === 1'b1 && s !== 1'b1) e++;
            s = sync_out;
        end
        if (e < 2) begin fails++; conclude(); end
        `CHK(n, exp, c)
    endtask
    // Internal period 50 cycles at half period 25; the sync source runs at 40 cycles.
    task t_sync;
        @(posedge clk_in) freq_set <= 16'h0019;
        sync_period("osc_free", 100);
        @(posedge clk_in) sync_on <= 1'b1;
        cyc(200); #1;
        `CHK("lock", 1'b1, lock)
        sync_period("sync_sw", 80);
        @(posedge clk_in) sync_lo <= 1'b1;
        sync_period("strap_lo", 40);
        @(posedge clk_in) begin
            sync_lo <= 1'b0;
            sync_hi <= 1'b1;
        end
        sync_period("strap_hi", 80);
        @(posedge clk_in) begin
            sync_hi <= 1'b0;
            sync_on <= 1'b0;
        end
        cyc(200); #1;
        `CHK("unlock", 1'b0, lock)
        sync_period("fallback", 100);
    endtask
    initial begin
        do_reset(1'b0);
        `CHK("rst_a", 2'h2, phase_a_out)
        `CHK("dual", 1'b0, single_phase_out)
        count_lows(0);
        `CHK("boot", `TLP_REFRESH_COUNT, na)
        `CHK("width", 0, bw)
        `CHK("b_pulses", 1'b1, nb > 0)
        t_trip();
        @(posedge clk_in) run_in <= 1'b0;
        cyc(3); #1;
        `CHK("mid_a", 2'h2, phase_a_out)
        count_lows(300);
        `CHK("extra", `TLP_REFRESH_EXTRA, na)
        `CHK("ex_width", 0, bw)
        t_fault();
        do_reset(1'b1);
        `CHK("single", 1'b1, single_phase_out)
        count_lows(0);
        `CHK("single_a", `TLP_REFRESH_COUNT, na)
        `CHK("single_b", 0, nb)
        t_sync();
        conclude();
    end
endmodule // tb_top
